// ==== rtl/temp_monitor_control_regs.sv ====
`default_nettype none
`include "tm_defs.svh"
module temp_monitor_control_regs
    import tm_pkg::*;
#(
    parameter int unsigned SLOWEST_INTERVAL_CYCLES = `TM_SLOWEST_INTERVAL_CYCLES
)
(
    input  wire logic         mclk,        // 125 MHz clock
    input  wire logic         rst,         // sync reset, active high
    input  wire logic         ptr_wr,      // first byte of a write
    input  wire logic         data_wr,     // following data byte
    input  wire logic [7:0]   wdata,       // byte from serial engine
    input  wire logic         rd,          // read request
    output var  logic [7:0]   rd_data,     // byte read, next cycle
    output var  logic         conv_start,  // one-cycle start to converter
    input  wire logic         conv_done,   // results valid
    input  wire conv_result_s conv_result, // raw results
    output var  logic         overtemp_comparator_n, // low when over limit
    output var  logic         shared_pin_n // alert or second comparator
);
    ctrl_state_s s_reg;
    ctrl_state_s s_next;
    logic        start_pulse;
    logic        overtemp_comparator_n_local;
    logic        overtemp_comparator_n_remote;
    logic        second_overtemp_comparator_n_local;
    logic        second_overtemp_comparator_n_remote;
    logic [3:0]  out_of_limit;
    logic [8:0]  local_enc;
    logic [8:0]  remote_enc;
    logic [7:0]  rd_value;
    logic        pin_n;

    // Clamped and biased encoding; bit 8 marks a clamped result
    function automatic logic [8:0] encode_deg(input logic signed [9:0] deg,
                                              input logic ext);
        logic signed [10:0] v;
        logic signed [10:0] top;
        v = ext ? ($signed({deg[9], deg}) + `TM_EXT_BIAS) : $signed({deg[9], deg});
        top = ext ? `TM_EXT_MAX : `TM_BIN_MAX;
        if (v < 11'sd0)
        begin
            encode_deg = 9'h100;
        end
        else if (v > top)
        begin
            encode_deg = {1'b1, top[7:0]};
        end
        else
        begin
            encode_deg = {1'b0, v[7:0]};
        end
    endfunction

    tm_rate_timer #(
        .SLOWEST_INTERVAL_CYCLES (SLOWEST_INTERVAL_CYCLES)
    ) u_timer (
        .mclk  (mclk),
        .rst   (rst),
        .code  (s_reg.rate[3:0]),
        .halt  (s_reg.cfg.standby),
        .start (start_pulse)
    );

    // Comparators watch register contents, so standby writes re-evaluate them
    tm_hyst_comparator u_overtemp_comparator_n_local (
        .mclk    (mclk),
        .rst     (rst),
        .value   (s_reg.local_temp),
        .limit   (s_reg.lim.local_overtemp_comparator_n),
        .hyst    (s_reg.lim.hyst),
        .tripped (overtemp_comparator_n_local)
    );

    tm_hyst_comparator u_overtemp_comparator_n_remote (
        .mclk    (mclk),
        .rst     (rst),
        .value   (s_reg.rem_high),
        .limit   (s_reg.lim.rem_overtemp_comparator_n),
        .hyst    (s_reg.lim.hyst),
        .tripped (overtemp_comparator_n_remote)
    );

    tm_hyst_comparator u_second_overtemp_comparator_n_local (
        .mclk    (mclk),
        .rst     (rst),
        .value   (s_reg.local_temp),
        .limit   (s_reg.lim.local_high),
        .hyst    (s_reg.lim.hyst),
        .tripped (second_overtemp_comparator_n_local)
    );

    tm_hyst_comparator u_second_overtemp_comparator_n_remote (
        .mclk    (mclk),
        .rst     (rst),
        .value   (s_reg.rem_high),
        .limit   (s_reg.lim.rem_high_h),
        .hyst    (s_reg.lim.hyst),
        .tripped (second_overtemp_comparator_n_remote)
    );

    always_comb
    begin
        local_enc = encode_deg(conv_result.local_deg, s_reg.cfg.ext_range);
        remote_enc = encode_deg(conv_result.remote_deg, s_reg.cfg.ext_range);

        // Window comparisons on stored results
        out_of_limit[3] = s_reg.local_temp > s_reg.lim.local_high;
        out_of_limit[2] = s_reg.local_temp <= s_reg.lim.local_low;
        out_of_limit[1] = {s_reg.rem_high, s_reg.rem_low[7:6]} >
                          {s_reg.lim.rem_high_h, s_reg.lim.rem_high_l[7:6]};
        out_of_limit[0] = {s_reg.rem_high, s_reg.rem_low[7:6]} <=
                          {s_reg.lim.rem_low_h, s_reg.lim.rem_low_l[7:6]};

        rd_value = 8'h00;
        unique case (s_reg.ptr)
            `TM_RD_LOCAL_TEMP:      rd_value = s_reg.local_temp;
            `TM_RD_REMOTE_HIGH:     rd_value = s_reg.rem_high;
            `TM_RD_STATUS:          rd_value = {s_reg.busy, s_reg.flags, 1'b0,
                                                overtemp_comparator_n_remote, overtemp_comparator_n_local};
            `TM_RD_CONFIG:          rd_value = s_reg.cfg;
            `TM_RD_RATE:            rd_value = s_reg.rate;
            `TM_RD_LOCAL_HIGH_LIM:  rd_value = s_reg.lim.local_high;
            `TM_RD_LOCAL_LOW_LIM:   rd_value = s_reg.lim.local_low;
            `TM_RD_REM_HIGH_LIM_H:  rd_value = s_reg.lim.rem_high_h;
            `TM_RD_REM_LOW_LIM_H:   rd_value = s_reg.lim.rem_low_h;
            `TM_RD_REMOTE_LOW:      rd_value = s_reg.rem_low;
            `TM_RW_REM_HIGH_LIM_L:  rd_value = s_reg.lim.rem_high_l;
            `TM_RW_REM_LOW_LIM_L:   rd_value = s_reg.lim.rem_low_l;
            `TM_RW_REM_OVERTEMP_COMPARATOR_N_LIM:   rd_value = s_reg.lim.rem_overtemp_comparator_n;
            `TM_RW_LOCAL_OVERTEMP_COMPARATOR_N_LIM: rd_value = s_reg.lim.local_overtemp_comparator_n;
            `TM_RW_HYSTERESIS:      rd_value = s_reg.lim.hyst;
            default:                rd_value = 8'h00;
        endcase

        s_next = s_reg;

        // Pointer and register writes
        if (ptr_wr)
        begin
            s_next.ptr = wdata;
        end
        else if (data_wr)
        begin
            unique case (s_reg.ptr)
                `TM_WR_CONFIG:          s_next.cfg = wdata;
                `TM_WR_RATE:            s_next.rate = wdata;
                `TM_WR_LOCAL_HIGH_LIM:  s_next.lim.local_high = wdata;
                `TM_WR_LOCAL_LOW_LIM:   s_next.lim.local_low = wdata;
                `TM_WR_REM_HIGH_LIM_H:  s_next.lim.rem_high_h = wdata;
                `TM_WR_REM_LOW_LIM_H:   s_next.lim.rem_low_h = wdata;
                `TM_RW_REM_HIGH_LIM_L:  s_next.lim.rem_high_l = wdata;
                `TM_RW_REM_LOW_LIM_L:   s_next.lim.rem_low_l = wdata;
                `TM_RW_REM_OVERTEMP_COMPARATOR_N_LIM:   s_next.lim.rem_overtemp_comparator_n = wdata;
                `TM_RW_LOCAL_OVERTEMP_COMPARATOR_N_LIM: s_next.lim.local_overtemp_comparator_n = wdata;
                `TM_RW_HYSTERESIS:      s_next.lim.hyst = wdata;
                default:                s_next.ptr = s_reg.ptr;
            endcase
        end

        // Reads: answer one cycle later, side effects on this edge
        if (rd)
        begin
            s_next.rd_data = rd_value;
            if (s_reg.ptr == `TM_RD_REMOTE_LOW)
            begin
                s_next.freeze = 1'b1;
            end
            else if (s_reg.ptr == `TM_RD_REMOTE_HIGH)
            begin
                s_next.freeze = 1'b0;
            end
            else if (s_reg.ptr == `TM_RD_STATUS)
            begin
                // Flags only clear once their condition has gone away
                s_next.flags = s_reg.flags & out_of_limit;
            end
        end

        // Conversion sequencing
        if (start_pulse)
        begin
            s_next.busy = 1'b1;
        end
        if (conv_done)
        begin
            s_next.busy = 1'b0;
            s_next.local_temp = local_enc[7:0];
            if (!s_reg.freeze)
            begin
                s_next.rem_high = remote_enc[7:0];
            end
            // A clamped reading carries no fraction
            s_next.rem_low = remote_enc[8] ? 8'h00 : {conv_result.remote_frac, 6'h00};
        end

        // Set wins over a same-cycle status read clear
        s_next.flags = s_next.flags | out_of_limit;

        s_next.overtemp_comparator_n_n = ~(overtemp_comparator_n_local | overtemp_comparator_n_remote);
        s_next.alert_n = pin_n;
    end

    always_comb
    begin
        if (s_reg.cfg.shared_pin_function_select)
        begin
            pin_n = ~(second_overtemp_comparator_n_local | second_overtemp_comparator_n_remote);
        end
        else
        begin
            pin_n = ~((|s_reg.flags) & ~s_reg.cfg.alert_mask_bit);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.ptr <= `TM_PTR_RESET;
            s_reg.cfg <= `TM_CONFIG_RESET;
            s_reg.rate <= `TM_RATE_RESET;
            s_reg.lim.local_high <= `TM_HIGH_LIM_RESET;
            s_reg.lim.local_low <= `TM_LOW_LIM_RESET;
            s_reg.lim.rem_high_h <= `TM_HIGH_LIM_RESET;
            s_reg.lim.rem_low_h <= `TM_LOW_LIM_RESET;
            s_reg.lim.rem_overtemp_comparator_n <= `TM_OVERTEMP_COMPARATOR_N_LIM_RESET;
            s_reg.lim.local_overtemp_comparator_n <= `TM_OVERTEMP_COMPARATOR_N_LIM_RESET;
            s_reg.lim.hyst <= `TM_HYST_RESET;
            s_reg.alert_n <= 1'b1;
            s_reg.overtemp_comparator_n_n <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd_data;
    assign overtemp_comparator_n = s_reg.overtemp_comparator_n_n;
    assign shared_pin_n = s_reg.alert_n;

    // Start pulse is already a flop in the timer
    assign conv_start = start_pulse;
endmodule
`default_nettype wire

// ==== rtl/tm_defs.svh ====
`ifndef TM_DEFS_SVH
`define TM_DEFS_SVH

`define TM_RD_LOCAL_TEMP      8'h00
`define TM_RD_REMOTE_HIGH     8'h01
`define TM_RD_STATUS          8'h02
`define TM_RD_CONFIG          8'h03
`define TM_RD_RATE            8'h04
`define TM_RD_LOCAL_HIGH_LIM  8'h05
`define TM_RD_LOCAL_LOW_LIM   8'h06
`define TM_RD_REM_HIGH_LIM_H  8'h07
`define TM_RD_REM_LOW_LIM_H   8'h08
`define TM_WR_CONFIG          8'h09
`define TM_WR_RATE            8'h0a
`define TM_WR_LOCAL_HIGH_LIM  8'h0b
`define TM_WR_LOCAL_LOW_LIM   8'h0c
`define TM_WR_REM_HIGH_LIM_H  8'h0d
`define TM_WR_REM_LOW_LIM_H   8'h0e
`define TM_RD_REMOTE_LOW      8'h10
`define TM_RW_REM_HIGH_LIM_L  8'h13
`define TM_RW_REM_LOW_LIM_L   8'h14
`define TM_RW_REM_OVERTEMP_COMPARATOR_N_LIM   8'h19
`define TM_RW_LOCAL_OVERTEMP_COMPARATOR_N_LIM 8'h20
`define TM_RW_HYSTERESIS      8'h21

`define TM_PTR_RESET          8'h00
`define TM_CONFIG_RESET       8'h00
`define TM_RATE_RESET         8'h08
`define TM_HIGH_LIM_RESET     8'h55
`define TM_LOW_LIM_RESET      8'h00
`define TM_OVERTEMP_COMPARATOR_N_LIM_RESET    8'h55
`define TM_HYST_RESET         8'h0a

`define TM_RATE_MAX_CODE      4'ha
`define TM_EXT_BIAS           11'sd64
`define TM_BIN_MAX            11'sd127
`define TM_EXT_MAX            11'sd255

`define TM_MCLK_MHZ           125
`define TM_SLOWEST_INTERVAL_MS 16000
`define TM_SLOWEST_INTERVAL_CYCLES (`TM_SLOWEST_INTERVAL_MS * 1000 * `TM_MCLK_MHZ)

`endif

// ==== rtl/tm_pkg.sv ====
`default_nettype none
package tm_pkg;

    typedef struct packed {
        logic       alert_mask_bit;
        logic       standby;
        logic       shared_pin_function_select;
        logic [1:0] rsvd_hi;
        logic       ext_range;
        logic [1:0] rsvd_lo;
    } config_s;

    // Raw converter output: signed whole degrees plus quarter-degree fraction
    typedef struct packed {
        logic signed [9:0] local_deg;
        logic signed [9:0] remote_deg;
        logic [1:0]        remote_frac;
    } conv_result_s;

    typedef struct packed {
        logic [7:0] local_high;
        logic [7:0] local_low;
        logic [7:0] rem_high_h;
        logic [7:0] rem_high_l;
        logic [7:0] rem_low_h;
        logic [7:0] rem_low_l;
        logic [7:0] rem_overtemp_comparator_n;
        logic [7:0] local_overtemp_comparator_n;
        logic [7:0] hyst;
    } limits_s;

    typedef struct packed {
        logic [7:0] ptr;
        config_s    cfg;
        logic [7:0] rate;
        logic [7:0] local_temp;
        logic [7:0] rem_high;
        logic [7:0] rem_low;
        limits_s    lim;
        logic [3:0] flags;      // local high, local low, remote high, remote low
        logic       freeze;
        logic       busy;
        logic [7:0] rd_data;
        logic       alert_n;
        logic       overtemp_comparator_n_n;
    } ctrl_state_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic        start;
    } timer_state_s;

endpackage
`default_nettype wire

// ==== rtl/tm_rate_timer.sv ====
`default_nettype none
`include "tm_defs.svh"
module tm_rate_timer
    import tm_pkg::*;
#(
    parameter int unsigned SLOWEST_INTERVAL_CYCLES = `TM_SLOWEST_INTERVAL_CYCLES
)
(
    input  wire logic       mclk,    // 125 MHz clock
    input  wire logic       rst,     // sync reset
    input  wire logic [3:0] code,    // rate code
    input  wire logic       halt,    // standby
    output var  logic       start    // one-cycle conversion start
);
    timer_state_s s_reg;
    timer_state_s s_next;
    logic [3:0]   code_eff;
    logic [31:0]  interval;

    always_comb
    begin
        // Reserved codes run at the fastest rate rather than stopping
        code_eff = (code > `TM_RATE_MAX_CODE) ? `TM_RATE_MAX_CODE : code;
        interval = SLOWEST_INTERVAL_CYCLES >> code_eff;
        s_next = s_reg;
        s_next.start = 1'b0;
        if (halt)
        begin
            s_next.cnt = '0;
        end
        else if (s_reg.cnt >= interval - 32'd1)
        begin
            // Compare, not equal: a shortened interval must not wrap the count
            s_next.cnt = '0;
            s_next.start = 1'b1;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 32'd1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign start = s_reg.start;
endmodule
`default_nettype wire

// ==== rtl/tm_hyst_comparator.sv ====
`default_nettype none
module tm_hyst_comparator
    import tm_pkg::*;
(
    input  wire logic       mclk,    // 125 MHz clock
    input  wire logic       rst,     // sync reset
    input  wire logic [7:0] value,   // encoded temperature
    input  wire logic [7:0] limit,   // encoded limit
    input  wire logic [7:0] hyst,    // hysteresis in degrees
    output var  logic       tripped  // high from over limit until at or below limit minus hyst
);
    logic              act_reg;
    logic              act_next;
    logic signed [9:0] release_at;

    always_comb
    begin
        release_at = $signed({2'b00, limit}) - $signed({2'b00, hyst});
        act_next = act_reg;
        if (!act_reg && value > limit)
        begin
            act_next = 1'b1;
        end
        else if (act_reg && $signed({2'b00, value}) <= release_at)
        begin
            // A hysteresis above the limit can never release below zero
            act_next = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            act_reg <= 1'b0;
        end
        else
        begin
            act_reg <= act_next;
        end
    end

    assign tripped = act_reg;
endmodule
`default_nettype wire

// ==== tb/tm_conv_model.sv ====
`default_nettype none
module tm_conv_model
    import tm_pkg::*;
#(
    parameter int DELAY = 3
)
(
    input  wire logic              mclk,       // clock
    input  wire logic              rst,        // sync reset
    input  wire logic              conv_start, // start from block
    input  wire logic signed [9:0] loc_deg,    // local degrees
    input  wire logic signed [9:0] rem_deg,    // remote degrees
    input  wire logic [1:0]        rem_frac,   // remote quarters
    output logic                   conv_done,  // result strobe
    output conv_result_s           conv_result // result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    always_ff @(posedge mclk)
    begin
        if (rst)
            cnt_reg <= 4'h0;
        else if (conv_start)
            cnt_reg <= 4'(DELAY);
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end
    assign conv_done = (cnt_reg == 4'h1);
    // Inverted outside the strobe so a stale capture cannot pass
    assign conv_result = conv_done ? {loc_deg, rem_deg, rem_frac}
                                   : ~{loc_deg, rem_deg, rem_frac};
endmodule
`default_nettype wire

// ==== tb/tm_regs_chk.sv ====
`default_nettype none
module tm_regs_chk
    import tm_pkg::*;
#(
    parameter int unsigned SLOWEST_INTERVAL_CYCLES = 4096
)
(
    input wire logic         mclk,                  // clock
    input wire logic         rst,                   // sync reset
    input wire logic         ptr_wr,                // pointer byte
    input wire logic         data_wr,               // data byte
    input wire logic [7:0]   wdata,                 // byte
    input wire logic         rd,                    // read
    input wire logic [7:0]   rd_data,               // read byte
    input wire logic         conv_start,            // start pulse
    input wire logic         conv_done,             // result strobe
    input wire conv_result_s conv_result,           // results
    input wire logic         overtemp_comparator_n, // comparator
    input wire logic         shared_pin_n           // shared pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  ptr_reg;
    logic [7:0]  cfg_reg;
    logic [7:0]  rate_reg;
    logic [7:0]  age_reg;
    logic [7:0]  hush_reg;
    logic [7:0]  mute_reg;
    logic [15:0] gap_reg;
    logic        clean_reg;
    logic [31:0] ival;
    assign ival = SLOWEST_INTERVAL_CYCLES >> ((rate_reg[3:0] > 4'ha) ? 4'ha : rate_reg[3:0]);
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ptr_reg <= 8'h00;
            cfg_reg <= 8'h00;
            rate_reg <= 8'h08;
            age_reg <= 8'h00;
            hush_reg <= 8'h00;
            mute_reg <= 8'h00;
            gap_reg <= 16'h0000;
            clean_reg <= 1'b0;
        end
        else
        begin
            if (ptr_wr)
                ptr_reg <= wdata;
            if (data_wr && !ptr_wr && ptr_reg == 8'h09)
                cfg_reg <= wdata;
            if (data_wr && !ptr_wr && ptr_reg == 8'h0a)
                rate_reg <= wdata;
            age_reg <= (conv_done || data_wr) ? 8'h00 : age_reg + 8'(age_reg != 8'hff);
            hush_reg <= cfg_reg[6] ? hush_reg + 8'(hush_reg != 8'hff) : 8'h00;
            mute_reg <= (cfg_reg[7] && !cfg_reg[5]) ? mute_reg + 8'(mute_reg != 8'hff) : 8'h00;
            gap_reg <= conv_start ? 16'h0000 : gap_reg + 16'h1;
            // Any rate or mode write may restart the timer
            clean_reg <= conv_start | (clean_reg & ~(data_wr & (ptr_reg inside {8'h09, 8'h0a})));
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_RESET_OUT: assert property (disable iff (1'b0) rst |=> rd_data == 8'h00 && !conv_start
        && overtemp_comparator_n && shared_pin_n) else $error("outputs not at reset values");
    AST_START_PULSE: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    AST_INTERVAL: assert property (conv_start && clean_reg |-> 32'(gap_reg) == ival - 1)
        else $error("conversion interval does not match rate code");
    AST_STANDBY: assert property (hush_reg >= 8'd4 |-> !conv_start)
        else $error("conversion started in standby");
    AST_RD_HOLD: assert property (!rd |=> $stable(rd_data))
        else $error("read data changed without a read");
    AST_CFG_READ: assert property (rd && ptr_reg == 8'h03 |=> rd_data == cfg_reg)
        else $error("configuration read back wrong");
    AST_RATE_READ: assert property (rd && ptr_reg == 8'h04 |=> rd_data == rate_reg)
        else $error("rate read back wrong");
    AST_MASK: assert property (mute_reg >= 8'd4 |-> shared_pin_n)
        else $error("masked alert driven low");
    AST_OT_CAUSE: assert property ($changed(overtemp_comparator_n) |-> age_reg <= 8'd6)
        else $error("comparator moved without a result or write");
    COV_INTERVAL: cover property (conv_start && clean_reg);
    COV_OT: cover property (!overtemp_comparator_n);
    COV_SECOND: cover property (!shared_pin_n && cfg_reg[5]);
endmodule
bind temp_monitor_control_regs tm_regs_chk #(.SLOWEST_INTERVAL_CYCLES(SLOWEST_INTERVAL_CYCLES))
    chk (.mclk(mclk), .rst(rst), .ptr_wr(ptr_wr), .data_wr(data_wr), .wdata(wdata), .rd(rd),
    .rd_data(rd_data), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .overtemp_comparator_n(overtemp_comparator_n),
    .shared_pin_n(shared_pin_n));
`default_nettype wire

// ==== tb/temp_monitor_control_regs_tb.sv ====
`default_nettype none
module temp_monitor_control_regs_tb
    import tm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SLOW = 4096;
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    logic              ptr_wr = 1'b0;
    logic              data_wr = 1'b0;
    logic              rd = 1'b0;
    logic [7:0]        wdata = 8'h00;
    logic signed [9:0] loc_deg = '0;
    logic signed [9:0] rem_deg = '0;
    logic [1:0]        rem_frac = 2'b00;
    logic [7:0]        rd_data;
    logic              conv_start;
    logic              conv_done;
    logic              ot_n;
    logic              sh_n;
    conv_result_s      conv_result;
    logic [15:0]       lfsr = 16'hc3d2;
    logic [23:0]       rd_q[$];
    int                errors = 0;
    int                check_count = 0;
    int                tdeg[8] = '{-1, 128, 127, 0, -65, 191, 10, -55};
    logic [7:0]        texp[8] = '{8'h00, 8'h7f, 8'h7f, 8'h00, 8'h00, 8'hff, 8'h4a, 8'h09};
    logic [7:0]        ra[11] = '{8'h00, 8'h01, 8'h10, 8'h03, 8'h04, 8'h21, 8'h05, 8'h06,
                                  8'h07, 8'h08, 8'hff};
    logic [7:0]        re[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0a, 8'h55, 8'h00,
                                  8'h55, 8'h00, 8'h00};
    int                hl[5] = '{61, 56, 55, 60, 61};
    logic              he[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0]        lw[7] = '{8'h0b, 8'h0c, 8'h0d, 8'h13, 8'h14, 8'h19, 8'h20};
    logic [7:0]        lr[7] = '{8'h05, 8'h06, 8'h07, 8'h13, 8'h14, 8'h19, 8'h20};
    always #4 mclk = ~mclk;
    temp_monitor_control_regs #(.SLOWEST_INTERVAL_CYCLES(SLOW)) dut (.mclk(mclk), .rst(rst),
        .ptr_wr(ptr_wr), .data_wr(data_wr), .wdata(wdata), .rd(rd), .rd_data(rd_data),
        .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
        .overtemp_comparator_n(ot_n), .shared_pin_n(sh_n));
    tm_conv_model #(.DELAY(3)) conv (.mclk(mclk), .rst(rst), .conv_start(conv_start),
        .loc_deg(loc_deg), .rem_deg(rem_deg), .rem_frac(rem_frac), .conv_done(conv_done),
        .conv_result(conv_result));
    task automatic check_byte(string what, logic [7:0] e, logic [7:0] g, logic [7:0] m);
        check_count++;
        if ((g & m) !== (e & m))
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic check_bit(string what, logic e, logic g);
        check_byte(what, {7'h0, e}, {7'h0, g}, 8'h01);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge mclk);
        ptr_wr = 1'b1;
        wdata = a;
        @(negedge mclk);
        ptr_wr = 1'b0;
        data_wr = 1'b1;
        wdata = d;
        @(negedge mclk);
        data_wr = 1'b0;
        wdata = ~d;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff, bit setp = 1);
        @(negedge mclk);
        if (setp)
        begin
            ptr_wr = 1'b1;
            wdata = a;
            @(negedge mclk);
            ptr_wr = 1'b0;
            wdata = ~a;
        end
        rd_q.push_back({a, m, e});
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
    endtask
    task automatic wait_start();
        for (int n = 0; n < 1000 && conv_start !== 1'b1; n++)
            @(negedge mclk);
        check_bit("conv_start", 1'b1, conv_start);
        @(negedge mclk);
    endtask
    task automatic cv(int l, int r, logic [1:0] f = 2'b00);
        int n;
        @(negedge mclk);
        loc_deg = l[9:0];
        rem_deg = r[9:0];
        rem_frac = f;
        for (n = 0; n < 300 && conv_done !== 1'b1; n++)
            @(negedge mclk);
        check_bit("conv_done", 1'b1, conv_done);
        repeat (4) @(negedge mclk);
    endtask
    task automatic pins(logic eo, logic es);
        repeat (4) @(negedge mclk);
        check_bit("overtemp_comparator_n", eo, ot_n);
        check_bit("shared_pin_n", es, sh_n);
    endtask
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        logic [23:0] q;
        forever
        begin
            @(posedge mclk);
            if (rd === 1'b1)
            begin
                @(posedge mclk);
                #1;
                q = rd_q.pop_front();
                check_byte($sformatf("register %h", q[23:16]), q[7:0], rd_data, q[15:8]);
            end
        end
    end
    // Whole sequence needs well under 2000 cycles; fifteen times that is a hang
    initial
    begin
        repeat (30000) @(posedge mclk);
        errors++;
        $display("unexpected watchdog: expected end of tests, seen none");
        end_of_test();
    end
    initial
    begin
        int n;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        rdc(8'h00, 8'h00, 8'hff, 0);
        wr(8'h00, 8'haa);
        wr(8'h03, 8'hff);
        for (int i = 0; i < 11; i++)
            rdc(ra[i], re[i]);
        // Reset results sit on the default low limit, so alert is already low
        pins(1'b1, 1'b0);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            if (i == 4)
                wr(8'h09, 8'h04);
            cv(tdeg[i], tdeg[i]);
            rdc(8'h00, texp[i]);
            rdc(8'h01, texp[i]);
        end
        rdc(8'h05, 8'h55);
        wr(8'h0e, 8'h4a);
        rdc(8'h08, 8'h4a);
        wr(8'h09, 8'h00);
        wr(8'h0e, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = lfsr_next(lfsr);
            cv(int'(lfsr[6:0]), 20);
            rdc(8'h00, {1'b0, lfsr[6:0]});
        end
        $display("format test done");
        cv(20, 40, 2'b10);
        rdc(8'h10, 8'h80);
        cv(20, 50);
        rdc(8'h01, 8'h28);
        cv(20, 50);
        rdc(8'h01, 8'h32);
        $display("freeze test done");
        cv(20, 20);
        // All four window flags were left set by the format test; busy ignored
        rdc(8'h02, 8'h78, 8'h7f);
        wr(8'h20, 8'd60);
        wr(8'h21, 8'h05);
        rdc(8'h21, 8'h05);
        for (int i = 0; i < 5; i++)
        begin
            cv(hl[i], 20);
            pins(he[i], 1'b0 | !(hl[i] > 85));
        end
        cv(20, 85);
        pins(1'b1, 1'b1);
        cv(20, 86);
        pins(1'b0, 1'b0);
        wr(8'h09, 8'h80);
        pins(1'b0, 1'b1);
        wr(8'h09, 8'ha0);
        pins(1'b0, 1'b0);
        cv(20, 20);
        pins(1'b1, 1'b1);
        wr(8'h09, 8'h00);
        pins(1'b1, 1'b0);
        rdc(8'h02, 8'h10, 8'h7c);
        pins(1'b1, 1'b1);
        cv(1, 20);
        pins(1'b1, 1'b1);
        cv(0, 20);
        pins(1'b1, 1'b0);
        cv(20, 20);
        rdc(8'h02, 8'h20, 8'h7c);
        pins(1'b1, 1'b1);
        $display("limit test done");
        wr(8'h09, 8'h40);
        n = 0;
        repeat (64)
        begin
            @(negedge mclk);
            n += int'(conv_start === 1'b1);
        end
        check_byte("starts in standby", 8'h00, 8'(n), 8'hff);
        wr(8'h20, 8'd10);
        pins(1'b0, 1'b1);
        wr(8'h20, 8'd60);
        pins(1'b1, 1'b1);
        rdc(8'h03, 8'h40);
        wr(8'h09, 8'h00);
        $display("standby test done");
        for (int c = 6; c < 12; c++)
        begin
            wr(8'h0a, 8'(c));
            rdc(8'h04, 8'(c));
            wait_start();
            wait_start();
            for (n = 1; n < 1000 && conv_start !== 1'b1; n++)
                @(negedge mclk);
            check_byte("interval", 8'(SLOW >> ((c > 10) ? 10 : c)), 8'(n), 8'hff);
        end
        wr(8'h0a, 8'h08);
        $display("rate test done");
        for (int i = 0; i < 7; i++)
        begin
            wr(lw[i], 8'h30 + 8'(i));
            rdc(lr[i], 8'h30 + 8'(i));
        end
        $display("limit register test done");
        repeat (4) @(negedge mclk);
        end_of_test();
    end
endmodule
`default_nettype wire
